// >>> rtsic_map.vh
`ifndef RTSIC_MAP_VH
`define RTSIC_MAP_VH

// register byte offsets
`define RTSIC_OFS_CTRL     12'h000
`define RTSIC_OFS_STATUS   12'h004
`define RTSIC_OFS_ILLCNT   12'h008

// control register fields
`define RTSIC_CTRL_ADDR_LSB 0
`define RTSIC_CTRL_SRQ      5
`define RTSIC_CTRL_SSF      6
`define RTSIC_CTRL_TF       7
`define RTSIC_CTRL_FAIL     8
`define RTSIC_CTRL_BLOCK    9
`define RTSIC_CTRL_MON      10
`define RTSIC_CTRL_RST      32'h0000_0000

// status word bit positions (bit time t sits at bit 19-t)
`define RTSIC_SW_ME   10
`define RTSIC_SW_INS  9
`define RTSIC_SW_SRQ  8
`define RTSIC_SW_BCR  4
`define RTSIC_SW_BSY  3
`define RTSIC_SW_SSF  2
`define RTSIC_SW_DBC  1
`define RTSIC_SW_TF   0

// command word fields and special values
`define RTSIC_BCAST_ADDR 5'h1F
`define RTSIC_MODE_SA0   5'h00
`define RTSIC_MODE_SA1   5'h1F
`define RTSIC_RT_A       5'h03
`define RTSIC_RT_B       5'h08

`endif

// >>> rtsic_classify.v
`timescale 1ns/1ps
`include "rtsic_map.vh"
module rtsic_classify (
  // own terminal address and command fields
  input  wire [4:0] rt_addr,
  input  wire [4:0] sub_addr,
  input  wire [4:0] mode_code,
  // verdict
  output reg        is_mode,
  output reg        illegal
);
  always @*
  begin
    is_mode = (sub_addr == `RTSIC_MODE_SA0) || (sub_addr == `RTSIC_MODE_SA1);
    illegal = 1'b0;
    if (is_mode)
    begin
      // undefined and reserved codes share one path
      if (mode_code <= 5'h01)
        illegal = 1'b1;
      else if (mode_code >= 5'h09 && mode_code <= 5'h0F)
        illegal = 1'b1;
      else if (mode_code >= 5'h14)
        illegal = 1'b1;
    end
    else if (rt_addr == `RTSIC_RT_A)
    begin
      illegal = (sub_addr >= 5'h07) && (sub_addr <= 5'h1D);
    end
    else if (rt_addr == `RTSIC_RT_B)
    begin
      illegal = (sub_addr == 5'h02) || (sub_addr == 5'h04) ||
                (sub_addr == 5'h0E) || (sub_addr == 5'h12) ||
                (sub_addr == 5'h18) || (sub_addr == 5'h1D);
    end
  end
endmodule

// >>> rtsic_top.v
// Added by the designer: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`include "rtsic_map.vh"
module rtsic_top (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // decoded command word from the word decoder
  input  wire        cmd_valid,
  input  wire [15:0] cmd_word,
  // subsystem failure pin
  input  wire        subsys_fail_pin,
  // response to the encoder and data path
  output reg         stat_valid,
  output reg  [15:0] stat_word,
  output reg         tx_data_en,
  output reg         rx_data_use,
  output reg         cmd_illegal
);
  // register state
  reg  [31:0] ctrl_q;
  reg  [15:0] illcnt_q;
  reg         bcr_q;
  reg         fail_s1_q;
  reg         fail_s2_q;

  // bus pipeline
  reg         wr_pend_q;
  reg  [11:0] wr_addr_q;

  wire        acc     = hsel && hready && htrans[1];
  wire [11:0] ofs     = haddr[11:0];
  wire [4:0]  own     = ctrl_q[`RTSIC_CTRL_ADDR_LSB+4:`RTSIC_CTRL_ADDR_LSB];

  // command word fields
  wire [4:0]  c_addr  = cmd_word[15:11];
  wire        c_tx    = cmd_word[10];
  wire [4:0]  c_sa    = cmd_word[9:5];
  wire [4:0]  c_mc    = cmd_word[4:0];
  wire        c_bcast = (c_addr == `RTSIC_BCAST_ADDR);
  wire        c_mine  = (c_addr == own) || c_bcast;
  wire        c_mode;
  wire        c_ill;

  rtsic_classify u_class (
    .rt_addr   (own),
    .sub_addr  (c_sa),
    .mode_code (c_mc),
    .is_mode   (c_mode),
    .illegal   (c_ill)
  );

  // busy only from failure or blocked transfers
  wire        busy = fail_s2_q || ctrl_q[`RTSIC_CTRL_FAIL]
                     || ctrl_q[`RTSIC_CTRL_BLOCK];

  // status word assembly
  reg  [15:0] sw_d;
  always @*
  begin
    sw_d = 16'h0000;
    sw_d[15:11]          = own;
    sw_d[`RTSIC_SW_ME]   = c_ill;
    sw_d[`RTSIC_SW_INS]  = 1'b0;
    // software raises this only for aperiodic needs
    sw_d[`RTSIC_SW_SRQ]  = ctrl_q[`RTSIC_CTRL_SRQ];
    sw_d[7:5]            = 3'h0;
    sw_d[`RTSIC_SW_BCR]  = bcr_q;
    sw_d[`RTSIC_SW_BSY]  = busy;
    sw_d[`RTSIC_SW_SSF]  = ctrl_q[`RTSIC_CTRL_SSF];
    sw_d[`RTSIC_SW_DBC]  = 1'b0;
    sw_d[`RTSIC_SW_TF]   = ctrl_q[`RTSIC_CTRL_TF];
  end

  // failure pin synchroniser
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fail_s1_q <= 1'b0;
      fail_s2_q <= 1'b0;
    end
    else
    begin
      fail_s1_q <= subsys_fail_pin;
      fail_s2_q <= fail_s1_q;
    end
  end

  // command handling
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stat_valid  <= 1'b0;
      stat_word   <= 16'h0000;
      tx_data_en  <= 1'b0;
      rx_data_use <= 1'b0;
      cmd_illegal <= 1'b0;
      bcr_q       <= 1'b0;
      illcnt_q    <= 16'h0000;
    end
    else
    begin
      stat_valid <= 1'b0;
      if (cmd_valid)
      begin
        cmd_illegal <= c_mine && c_ill;
        // no data out on an illegal command or a broadcast
        tx_data_en  <= c_mine && !c_bcast && c_tx && !c_ill;
        // foreign data used only in monitor mode
        // the illegal tables judge own commands only, never foreign traffic
        rx_data_use <= !c_tx &&
                       (c_mine ? !c_ill : ctrl_q[`RTSIC_CTRL_MON]);
        if (c_mine && c_ill)
          illcnt_q <= illcnt_q + 16'h0001;
        if (c_mine && !c_bcast)
        begin
          stat_valid <= 1'b1;
          stat_word  <= sw_d;
        end
        // broadcast flag survives only until the next own command
        if (c_mine)
          bcr_q <= c_bcast && !c_ill;
      end
    end
  end

  // bus slave
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      ctrl_q    <= `RTSIC_CTRL_RST;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_q <= acc && hwrite;
      wr_addr_q <= ofs;
      if (wr_pend_q && wr_addr_q == `RTSIC_OFS_CTRL)
        ctrl_q <= {21'h000000, hwdata[10:0]};
      if (acc && !hwrite)
      begin
        if (ofs == `RTSIC_OFS_CTRL)
          hrdata <= ctrl_q;
        else if (ofs == `RTSIC_OFS_STATUS)
          hrdata <= {15'h0000, cmd_illegal, stat_word};
        else if (ofs == `RTSIC_OFS_ILLCNT)
          hrdata <= {16'h0000, illcnt_q};
        else
          hrdata <= 32'h0000_0000;
      end
    end
  end
endmodule

// >>> rtsic_properties.sv
`timescale 1ns/1ps
module rtsic_properties (
  // clock and reset
  input wire        hclk,
  input wire        hresetn,
  // command path
  input wire        cmd_valid,
  input wire [15:0] cmd_word,
  input wire        stat_valid,
  input wire [15:0] stat_word,
  input wire        tx_data_en,
  input wire        rx_data_use,
  input wire        cmd_illegal
);
  default clocking dcb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  instr_zero_a: assert property (stat_valid |-> !stat_word[9])
    else $error("instr bit set");
  rsvd_zero_a: assert property (stat_valid |-> stat_word[7:5] == 3'h0)
    else $error("reserved bits set");
  dbca_zero_a: assert property (stat_valid |-> !stat_word[1])
    else $error("bus control accepted");
  me_flag_a: assert property (stat_valid |-> stat_word[10] == cmd_illegal)
    else $error("message error wrong");
  ill_mute_a: assert property (cmd_illegal |-> !tx_data_en && !rx_data_use)
    else $error("data used on illegal");
  bad_mode_a: assert property (cmd_valid && cmd_word[15:11] == 5'h1F &&
    cmd_word[9:5] == 5'h00 && cmd_word[4:0] < 5'h02 |=> cmd_illegal)
    else $error("mode code not flagged");
  resp_only_a: assert property (stat_valid |-> $past(cmd_valid))
    else $error("status without command");
  out_hold_a: assert property (!cmd_valid |=> $stable(cmd_illegal) && $stable(stat_word))
    else $error("outputs moved");
endmodule

bind rtsic_top rtsic_properties u_props (.hclk, .hresetn, .cmd_valid, .cmd_word,
  .stat_valid, .stat_word, .tx_data_en, .rx_data_use, .cmd_illegal);

// >>> rtsic_bc_model.sv
`timescale 1ns/1ps
module rtsic_bc_model (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // request from the bench
  input  wire        go,
  input  wire [15:0] word,
  // command toward the terminal
  output reg         cmd_valid,
  output reg  [15:0] cmd_word
);
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cmd_valid <= 1'b0;
      cmd_word  <= 16'h0000;
    end
    else
    begin
      // sole initiator of commands toward the terminal
      cmd_valid <= go;
      // idle lines never repeat the last word
      cmd_word  <= go ? word : ~cmd_word;
    end
  end
endmodule

// >>> rtsic_top_tb.sv
`timescale 1ns/1ps
module rtsic_top_tb;
  reg         hclk, hresetn, hsel, hwrite, go, pin, bcr;
  reg  [1:0]  htrans;
  reg  [31:0] haddr, hwdata, rd, seed, ctrl, r;
  reg  [15:0] cw;
  wire        hreadyout, hresp, stat_valid, tx_data_en, rx_data_use, cmd_illegal, cmd_valid;
  wire [31:0] hrdata;
  wire [15:0] cmd_word, stat_word;
  integer     fail_count, checked, i;
  rtsic_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cmd_valid, .cmd_word,
    .subsys_fail_pin(pin), .stat_valid, .stat_word, .tx_data_en, .rx_data_use, .cmd_illegal);
  rtsic_bc_model bc (.hclk, .hresetn, .go, .word(cw), .cmd_valid, .cmd_word);
  initial
  begin
    hclk = 0;
    forever #20 hclk = ~hclk;
  end
  function automatic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic bit ill(input [4:0] own, sa, mc);
    if (sa == 5'h00 || sa == 5'h1F)
      return mc < 2 || (mc > 8 && mc < 16) || mc > 19;
    if (own == 5'h03)
      return sa > 6 && sa < 30;
    return own == 5'h08 && (sa == 2 || sa == 4 || sa == 14 || sa == 18 || sa == 24 || sa == 29);
  endfunction
  function automatic [15:0] sw(input il);
    return {ctrl[4:0], il, 1'b0, ctrl[5], 3'h0, bcr, ctrl[8] | ctrl[9] | pin, ctrl[6], 1'b0, ctrl[7]};
  endfunction
  task end_sim;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input [31:0] g, e);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wt;
    integer n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge hclk);
    end
    if (n >= 50)
    begin
      fail_count++;
      end_sim;
    end
  endtask
  task bus(input w, input [31:0] a, d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wt;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt;
    rd = hrdata;
  endtask
  task run(input [15:0] w);
    reg om, bc, il, md;
    om = w[15:11] == ctrl[4:0];
    bc = w[15:11] == 5'h1F;
    md = w[9:5] == 5'h00 || w[9:5] == 5'h1F;
    il = (om || bc) && ill(ctrl[4:0], w[9:5], w[4:0]);
    go <= 1'b1;
    cw <= w;
    @(posedge hclk);
    go <= 1'b0;
    @(posedge hclk);
    #1;
    chk(cmd_illegal, il);
    chk(stat_valid, om && !bc);
    if (om && !bc) chk(stat_word, sw(il));
    if (om && !bc) chk(stat_word[10], il);
    if (om && !bc) chk(stat_word[8], ctrl[5]);
    if (om && !bc) chk(stat_word[4], bcr);
    if (om && !bc) chk(stat_word[3], ctrl[8] | ctrl[9] | pin);
    if (om && !bc) chk(stat_word[2], ctrl[6]);
    if (om && !bc) chk(stat_word[0], ctrl[7]);
    if (!md) chk(tx_data_en, om && !bc && !il && w[10]);
    if (!md) chk(rx_data_use, (om || bc) ? !il && !w[10] : ctrl[10] && !w[10]);
    if (om || bc) bcr = bc && !il;
  endtask
  initial
  begin
    #400000;
    fail_count++;
    end_sim;
  end
  initial
  begin
    {fail_count, checked, hsel, htrans, haddr, hwrite, hwdata, go, cw, pin, ctrl, bcr} = 0;
    seed = 16;
    hresetn = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(0, 32'h0000_000C, 0);
    chk(rd, 0);
    bus(0, 0, 0);
    chk(rd, 0);
    ctrl = 32'h0000_0003;
    bus(1, 0, ctrl);
    for (i = 0; i < 64; i++) run({i[5] ? 5'h1F : 5'h03, 1'b1, 5'h00, i[4:0]});
    $display("mode sweep done");
    for (i = 0; i < 480; i++)
    begin
      if (i % 8 == 0)
      begin
        ctrl = xs() & 32'h0000_07E0 | (i % 24 < 8 ? 3 : i % 24 < 16 ? 8 : seed[4:0] & 5'h1E);
        pin <= seed[31];
        bus(1, 0, ctrl);
        bus(0, 0, 0);
        chk(rd, ctrl);
      end
      r = xs();
      run({r[2] ? ctrl[4:0] : r[1] ? 5'h1F : r[15:11], r[10:0]});
    end
    $display("random mix done");
    end_sim;
  end
endmodule
